// file: design/power_result_control_regs.sv
// page-0 result and control register bank of the power measurement core
// assumes: host port decoded from the serial port on clk; results strobed by
// the datapath on clk; a read answers one cycle after the request
`include "power_result_map.svh"
`timescale 1ns/10ps
`default_nettype none

module power_result_control_regs
  import power_result_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // host register port
  input  wire logic              host_wr_en,
  input  wire logic              host_rd_en,
  input  wire logic [`ADDR_W-1:0] host_addr,
  input  wire word_t             host_wdata,
  output word_t                  host_rdata,
  output logic                   host_rd_hit,
  // datapath results
  input  wire logic              result_update,
  input  wire word_t             identity_reactive_power,
  input  wire word_t             power_factor,
  input  wire word_t             apparent_power,
  input  wire word_t             harmonic_active_power,
  input  wire word_t             fundamental_active_power,
  input  wire word_t             fundamental_reactive_power,
  // control outputs
  output page_t                  page_select,
  output logic                   boot_stop,
  output logic                   oscillator_disable,
  // interrupt and clock pins
  input  wire logic              int_request,
  output logic                   int_pin_out,
  output logic                   int_pin_oe_n,
  output logic                   processor_clock_output
);

  // ==========================================================
  // declarations
  bank_state_t st_reg;
  bank_state_t st_next;
  word_t       result_in   [`RESULT_COUNT];
  word_t       result_held [`RESULT_COUNT];
  logic        on_page_zero;
  logic        write_page;
  logic        write_ctrl;
  pin_ctrl_if  pin_ctl ();

  // ==========================================================
  // result holding
  // results are held so that a slow serial read sees one
  // consistent word even while the datapath keeps running
  assign result_in[`IDX_IDENTITY_Q]     = identity_reactive_power;
  assign result_in[`IDX_POWER_FACTOR]   = power_factor;
  assign result_in[`IDX_APPARENT_POWER] = apparent_power;
  assign result_in[`IDX_HARMONIC_P]     = harmonic_active_power;
  assign result_in[`IDX_FUNDAMENTAL_P]  = fundamental_active_power;
  assign result_in[`IDX_FUNDAMENTAL_Q]  = fundamental_reactive_power;

  genvar gi;
  generate
    for (gi = 0; gi < `RESULT_COUNT; gi++)
    begin : g_hold
      // only the datapath loads a result; host writes never reach here
      result_word_hold u_hold (
        .clk   (clk),
        .reset (reset),
        .load  (result_update),
        .d     (result_in[gi]),
        .q     (result_held[gi])
      );
    end
  endgenerate

  // ==========================================================
  // address decode
  // the page register sits at the same address on every page, so a
  // host that strayed to another page can always get back
  assign on_page_zero = (st_reg.page == `PAGE_ZERO);
  assign write_page   = host_wr_en && (host_addr == `ADDR_PAGE_SELECT);
  assign write_ctrl   = host_wr_en && on_page_zero && (host_addr == `ADDR_DEVICE_CONTROL);

  // ==========================================================
  // bank next state
  always_comb
  begin
    st_next        = st_reg;
    st_next.rd_hit = 1'b0;
    // writes: page register wins address 31, result addresses are ignored
    if (write_page)
    begin
      st_next.page = host_wdata[`PAGE_W-1:0];
    end
    else if (write_ctrl)
    begin
      // undefined bits are forced to zero so they read back as zero
      st_next.ctrl = host_wdata & `CTRL_WRITE_MASK;
    end
    // reads: registered answer one cycle after the request
    if (host_rd_en)
    begin
      st_next.rdata = `WORD_ZERO;
      if (on_page_zero)
      begin
        unique case (host_addr)
          `ADDR_IDENTITY_Q:
          begin
            st_next.rdata  = result_held[`IDX_IDENTITY_Q];
            st_next.rd_hit = 1'b1;
          end
          `ADDR_POWER_FACTOR:
          begin
            st_next.rdata  = result_held[`IDX_POWER_FACTOR];
            st_next.rd_hit = 1'b1;
          end
          `ADDR_APPARENT_POWER:
          begin
            st_next.rdata  = result_held[`IDX_APPARENT_POWER];
            st_next.rd_hit = 1'b1;
          end
          `ADDR_DEVICE_CONTROL:
          begin
            st_next.rdata  = st_reg.ctrl;
            st_next.rd_hit = 1'b1;
          end
          `ADDR_HARMONIC_P:
          begin
            st_next.rdata  = result_held[`IDX_HARMONIC_P];
            st_next.rd_hit = 1'b1;
          end
          `ADDR_FUNDAMENTAL_P:
          begin
            st_next.rdata  = result_held[`IDX_FUNDAMENTAL_P];
            st_next.rd_hit = 1'b1;
          end
          `ADDR_FUNDAMENTAL_Q:
          begin
            // reads of 31 see the result, never the write-only page
            st_next.rdata  = result_held[`IDX_FUNDAMENTAL_Q];
            st_next.rd_hit = 1'b1;
          end
          default:
          begin
            // address 26 and the lower bank are not served here
            st_next.rdata  = `WORD_ZERO;
            st_next.rd_hit = 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // bank registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg.page   <= `PAGE_ZERO;
      st_reg.ctrl   <= `CTRL_RESET;
      st_reg.rdata  <= `WORD_ZERO;
      st_reg.rd_hit <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign host_rdata         = st_reg.rdata;
  assign host_rd_hit        = st_reg.rd_hit;
  assign page_select        = st_reg.page;
  assign boot_stop          = st_reg.ctrl[`CTRL_BOOT_STOP_BIT];
  assign oscillator_disable = st_reg.ctrl[`CTRL_OSC_DISABLE_BIT];

  // pin control levels
  assign pin_ctl.open_drain_select       = st_reg.ctrl[`CTRL_INT_OPEN_DRAIN_BIT];
  assign pin_ctl.processor_clock_disable = st_reg.ctrl[`CTRL_CPU_CLK_DISABLE_BIT];
  assign pin_ctl.int_request             = int_request;

  pin_drive u_pins (
    .clk                    (clk),
    .reset                  (reset),
    .ctl                    (pin_ctl.driver),
    .int_pin_out            (int_pin_out),
    .int_pin_oe_n           (int_pin_oe_n),
    .processor_clock_output (processor_clock_output)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_read_identity_q: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_IDENTITY_Q
    |=> host_rd_hit && host_rdata == $past(result_held[`IDX_IDENTITY_Q]))
    else $error("identity reactive power read wrong");

  a_read_power_factor: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_POWER_FACTOR
    |=> host_rd_hit && host_rdata == $past(result_held[`IDX_POWER_FACTOR]))
    else $error("power factor read wrong");

  a_read_apparent: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_APPARENT_POWER
    |=> host_rd_hit && host_rdata == $past(result_held[`IDX_APPARENT_POWER]))
    else $error("apparent power read wrong");

  a_boot_stop_set: assert property (
    write_ctrl && !write_page && host_wdata[`CTRL_BOOT_STOP_BIT]
    |=> boot_stop ##1 (boot_stop || $past(write_ctrl)))
    else $error("boot stop not taken");

  a_osc_disable_bit: assert property (
    write_ctrl && !write_page
    |=> oscillator_disable == $past(host_wdata[`CTRL_OSC_DISABLE_BIT]))
    else $error("oscillator disable not taken");

  a_read_harmonic: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_HARMONIC_P
    |=> host_rdata == $past(result_held[`IDX_HARMONIC_P]))
    else $error("harmonic power read wrong");

  a_read_fund_p: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_FUNDAMENTAL_P
    |=> host_rdata == $past(result_held[`IDX_FUNDAMENTAL_P]))
    else $error("fundamental active power read wrong");

  a_read_fund_q: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_FUNDAMENTAL_Q
    |=> host_rd_hit && host_rdata == $past(result_held[`IDX_FUNDAMENTAL_Q]))
    else $error("fundamental reactive power read wrong");

  a_page_write: assert property (
    write_page |=> page_select == $past(host_wdata[`PAGE_W-1:0]) && $stable(st_reg.ctrl))
    else $error("page select not loaded");

  a_page_hold: assert property (
    !write_page |=> $stable(page_select))
    else $error("page select changed without a write");

  a_off_page_read: assert property (
    host_rd_en && !on_page_zero |=> !host_rd_hit && host_rdata == `WORD_ZERO)
    else $error("bank answered off page zero");

  a_ctrl_undefined_zero: assert property (
    write_ctrl |=> (st_reg.ctrl & ~`CTRL_WRITE_MASK) == `WORD_ZERO)
    else $error("undefined control bit stored");

  a_result_write_ignored: assert property (
    host_wr_en && host_addr >= `ADDR_IDENTITY_Q && host_addr <= `ADDR_FUNDAMENTAL_P
    && host_addr != `ADDR_DEVICE_CONTROL
    |=> $stable(st_reg.ctrl) && $stable(page_select))
    else $error("result write changed the bank");

  // control read-back, storage and pin effects, seen from the bank's own
  // register so that a divider that fails to park or a broken pin stage is caught here as well
  a_read_ctrl: assert property (
    host_rd_en && on_page_zero && host_addr == `ADDR_DEVICE_CONTROL
    |=> host_rd_hit && host_rdata == $past(st_reg.ctrl))
    else $error("control read wrong");

  a_ctrl_store: assert property (
    write_ctrl |=> st_reg.ctrl == ($past(host_wdata) & `CTRL_WRITE_MASK))
    else $error("control write stored wrong");

  a_off_page_ctrl: assert property (
    host_wr_en && !on_page_zero && host_addr != `ADDR_PAGE_SELECT
    |=> $stable(st_reg.ctrl) && $stable(page_select))
    else $error("off page write reached the bank");

  a_boot_stop_clear: assert property (
    write_ctrl && !host_wdata[`CTRL_BOOT_STOP_BIT] |=> !boot_stop)
    else $error("boot stop not cleared");

  a_int_open_drain: assert property (
    st_reg.ctrl[`CTRL_INT_OPEN_DRAIN_BIT] && int_request
    |=> !int_pin_oe_n && !int_pin_out)
    else $error("open drain pin not pulled low");

  a_int_normal: assert property (
    !st_reg.ctrl[`CTRL_INT_OPEN_DRAIN_BIT]
    |=> !int_pin_oe_n && int_pin_out == !$past(int_request))
    else $error("driven interrupt pin wrong");

  a_cpu_clk_parked: assert property (
    st_reg.ctrl[`CTRL_CPU_CLK_DISABLE_BIT] |=> !processor_clock_output)
    else $error("processor clock not parked");

  a_idle_no_hit: assert property (
    !host_rd_en |=> !host_rd_hit && $stable(host_rdata))
    else $error("read answer without a read");

endmodule // power_result_control_regs

`default_nettype wire

// file: design/power_result_map.svh
// offsets, field positions, reset values and timing counts of the result/control bank
// assumes: 5-bit register address, 24-bit register words, page 0 holds this bank
`ifndef POWER_RESULT_MAP_SVH
`define POWER_RESULT_MAP_SVH

// ==========================================================
// register offsets
`define ADDR_W                    5
`define ADDR_IDENTITY_Q           5'h18
`define ADDR_POWER_FACTOR         5'h19
`define ADDR_APPARENT_POWER       5'h1b
`define ADDR_DEVICE_CONTROL       5'h1c
`define ADDR_HARMONIC_P           5'h1d
`define ADDR_FUNDAMENTAL_P        5'h1e
`define ADDR_FUNDAMENTAL_Q        5'h1f
`define ADDR_PAGE_SELECT          5'h1f

// ==========================================================
// widths and reset values
`define WORD_W                    24
`define PAGE_W                    7
`define PAGE_ZERO                 7'h00
`define CTRL_RESET                24'h00_0000
`define WORD_ZERO                 24'h00_0000

// ==========================================================
// control register fields
`define CTRL_BOOT_STOP_BIT        8
`define CTRL_INT_OPEN_DRAIN_BIT   4
`define CTRL_CPU_CLK_DISABLE_BIT  2
`define CTRL_OSC_DISABLE_BIT      1
`define CTRL_WRITE_MASK           24'h00_0116

// ==========================================================
// result slots held in the bank
`define RESULT_COUNT              6
`define IDX_IDENTITY_Q            0
`define IDX_POWER_FACTOR          1
`define IDX_APPARENT_POWER        2
`define IDX_HARMONIC_P            3
`define IDX_FUNDAMENTAL_P         4
`define IDX_FUNDAMENTAL_Q         5

// ==========================================================
// processor clock output divider
`define CPU_CLK_HALF_CYCLES       4'h2
`define CPU_CLK_CNT_W             4

`endif

// file: design/power_result_pkg.sv
// types of the result/control bank
// assumes: power_result_map.svh supplies the widths
`include "power_result_map.svh"

package power_result_pkg;

  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`PAGE_W-1:0] page_t;

  // state of the register bank
  typedef struct packed {
    page_t page;
    word_t ctrl;
    word_t rdata;
    logic  rd_hit;
  } bank_state_t;

  // state of one held result word
  typedef struct packed {
    word_t value;
  } hold_state_t;

  // state of the pin driver
  typedef struct packed {
    logic [`CPU_CLK_CNT_W-1:0] count;
    logic                      cpu_clk;
    logic                      int_out;
    logic                      int_oe_n;
  } pin_state_t;

endpackage

// file: design/pin_ctrl_if.sv
// control levels from the register bank to the pin driver
// assumes: one clock domain, both select levels registered in the bank, int_request passed straight through
`timescale 1ns/10ps
`default_nettype none

interface pin_ctrl_if;
  logic open_drain_select;
  logic processor_clock_disable;
  logic int_request;

  modport bank   (output open_drain_select, output processor_clock_disable, output int_request);
  modport driver (input open_drain_select, input processor_clock_disable, input int_request);
endinterface

`default_nettype wire

// file: design/result_word_hold.sv
// one held result word, reloaded when the datapath strobes a new result
// assumes: load is a one-cycle pulse on clk
`timescale 1ns/10ps
`default_nettype none

module result_word_hold
  import power_result_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // datapath side
  input  wire logic load,
  input  wire word_t d,
  // bank side
  output word_t     q
);

  hold_state_t st_reg;
  hold_state_t st_next;

  // ==========================================================
  // hold logic: only the datapath ever changes the word
  always_comb
  begin
    st_next = st_reg;
    if (load)
    begin
      st_next.value = d;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.value;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_hold_load:   assert property (load |=> q == $past(d)) else $error("result not loaded");
  a_hold_stable: assert property (!load |=> $stable(q)) else $error("result changed without load");

endmodule // result_word_hold

`default_nettype wire

// file: design/pin_drive.sv
// interrupt pin driver and processor clock output divider
// assumes: int_request is active high from same-clock logic; pin is active low
`include "power_result_map.svh"
`timescale 1ns/10ps
`default_nettype none

module pin_drive
  import power_result_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  reset,
  // control from the bank
  pin_ctrl_if.driver ctl,
  // pins
  output logic       int_pin_out,
  output logic       int_pin_oe_n,
  output logic       processor_clock_output
);

  pin_state_t st_reg;
  pin_state_t st_next;

  // ==========================================================
  // pin logic; oe_n low means the pin is driven
  always_comb
  begin
    st_next = st_reg;
    if (ctl.open_drain_select)
    begin
      // open drain: only ever pull low, release otherwise
      st_next.int_out  = 1'b0;
      st_next.int_oe_n = ~ctl.int_request;
    end
    else
    begin
      st_next.int_out  = ~ctl.int_request;
      st_next.int_oe_n = 1'b0;
    end
    // divider stops and parks low so the pin draws no switching power
    if (ctl.processor_clock_disable)
    begin
      st_next.count   = '0;
      st_next.cpu_clk = 1'b0;
    end
    else if (st_reg.count == `CPU_CLK_HALF_CYCLES - 4'h1)
    begin
      st_next.count   = '0;
      st_next.cpu_clk = ~st_reg.cpu_clk;
    end
    else
    begin
      st_next.count = st_reg.count + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      st_reg <= '{count: '0, cpu_clk: 1'b0, int_out: 1'b1, int_oe_n: 1'b0};
    else
      st_reg <= st_next;
  end

  assign int_pin_out            = st_reg.int_out;
  assign int_pin_oe_n           = st_reg.int_oe_n;
  assign processor_clock_output = st_reg.cpu_clk;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_open_drain_idle: assert property (ctl.open_drain_select && !ctl.int_request |=> int_pin_oe_n && !int_pin_out)
    else $error("open drain pin driven while idle");
  a_cpu_clk_off: assert property (ctl.processor_clock_disable [*2] |=> !processor_clock_output)
    else $error("processor clock runs while disabled");

endmodule // pin_drive

`default_nettype wire

// file: testbench/host_port_model.sv
// host processor model driving the register port of the result/control bank
// assumes: one clock, one-cycle request pulses launched just after a rising edge
`include "power_result_map.svh"
`timescale 1ns/10ps
`default_nettype none

module host_port_model
  import power_result_pkg::*;
(
  // clock
  input  wire logic               clk,
  // host register port
  output var  logic               host_wr_en,
  output var  logic               host_rd_en,
  output var  logic [`ADDR_W-1:0] host_addr,
  output var  word_t              host_wdata
);
  // ==========================================================
  // idle state of the port
  initial
  begin
    host_wr_en = 1'b0;
    host_rd_en = 1'b0;
    host_addr  = 5'h00;
    host_wdata = 24'h00_0000;
  end

  // one write pulse; the page is written before any access on another page
  // callers pass zero in undefined control bits unless a fault is meant
  task automatic wr(input logic [`ADDR_W-1:0] a, input word_t d);
    @(posedge clk);
    host_wr_en <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr_en <= 1'b0;
    host_addr  <= ~a; // released lines do not keep the old value
    host_wdata <= ~d;
  endtask

  // one read pulse; the answer is taken by the bench a cycle later
  task automatic rd(input logic [`ADDR_W-1:0] a);
    @(posedge clk);
    host_rd_en <= 1'b1;
    host_addr  <= a;
    @(posedge clk);
    host_rd_en <= 1'b0;
    host_addr  <= ~a;
  endtask
endmodule // host_port_model

`default_nettype wire

// file: testbench/power_result_control_regs_test.sv
// self-checking bench for the result/control register bank
// assumes: host_port_model drives the host port; bench drives results and pins
`include "power_result_map.svh"
`timescale 1ns/10ps
`default_nettype none

module power_result_control_regs_test;
  import power_result_pkg::*;

  logic clk, reset, host_wr_en, host_rd_en, host_rd_hit, result_update, int_request;
  logic boot_stop, oscillator_disable, int_pin_out, int_pin_oe_n, processor_clock_output;
  logic [`ADDR_W-1:0] host_addr;
  word_t host_wdata, host_rdata, w0, w1, w2, w3, w4, w5;
  page_t page_select;
  word_t res [6];
  logic [`ADDR_W-1:0] addr_tab [6] = '{`ADDR_IDENTITY_Q, `ADDR_POWER_FACTOR, `ADDR_APPARENT_POWER,
                                       `ADDR_HARMONIC_P, `ADDR_FUNDAMENTAL_P, `ADDR_FUNDAMENTAL_Q};
  logic [24:0] exp_q [$];
  logic [24:0] exp_v;
  logic        rd_pend = 1'b0;
  int err_count = 0, n_compared = 0, cycles = 0, i, n;
  integer seed = 32'ha31e1dfd;
  logic r;

  // ==========================================================
  // clock, design and host model
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  power_result_control_regs power_result_control_regs_inst (
    .clk(clk), .reset(reset), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rd_hit(host_rd_hit),
    .result_update(result_update), .identity_reactive_power(w0), .power_factor(w1),
    .apparent_power(w2), .harmonic_active_power(w3), .fundamental_active_power(w4),
    .fundamental_reactive_power(w5), .page_select(page_select), .boot_stop(boot_stop),
    .oscillator_disable(oscillator_disable), .int_request(int_request), .int_pin_out(int_pin_out),
    .int_pin_oe_n(int_pin_oe_n), .processor_clock_output(processor_clock_output));

  host_port_model host_port_model_inst (
    .clk(clk), .host_wr_en(host_wr_en), .host_rd_en(host_rd_en),
    .host_addr(host_addr), .host_wdata(host_wdata));

  // ==========================================================
  // checking helpers
  task automatic chk(input logic [24:0] got, input logic [24:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // note the expected {hit, data} first, then issue the read
  task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic hit, input word_t d);
    exp_q.push_back({hit, d});
    host_port_model_inst.rd(a);
  endtask

  // read answers land one cycle after the request edge; oldest note first
  always @(posedge clk)
  begin
    if (rd_pend)
    begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : ~{host_rd_hit, host_rdata};
      chk({host_rd_hit, host_rdata}, exp_v, "read answer");
    end
    rd_pend <= host_rd_en;
  end

  // hang guard, far above the roughly 160 cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count++;
      wrap_up;
    end
  end

  // interrupt pin walk: pins follow the request one cycle later
  task automatic pin_walk(input logic od);
    repeat (8)
    begin
      r = 1'($random(seed));
      @(posedge clk);
      int_request <= r;
      @(posedge clk);
      #1;
      chk({int_pin_oe_n, int_pin_out}, od ? {~r, 1'b0} : {1'b0, ~r}, "interrupt pin");
    end
  endtask

  // highs of the processor clock over eight cycles
  task automatic count_clk(output int k);
    k = 0;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      k += (processor_clock_output === 1'b1);
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    reset = 1'b1;
    result_update = 1'b0;
    int_request = 1'b0;
    {w0, w1, w2, w3, w4, w5} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk({page_select, boot_stop, oscillator_disable}, 0, "reset levels");
    rd_chk(`ADDR_DEVICE_CONTROL, 1'b1, `CTRL_RESET);
    $display("test reset done");

    // random results loaded, then every slot and two unmapped places read
    for (i = 0; i < 6; i++) res[i] = word_t'($random(seed));
    @(posedge clk);
    result_update <= 1'b1;
    {w0, w1, w2, w3, w4, w5} <= {res[0], res[1], res[2], res[3], res[4], res[5]};
    @(posedge clk);
    result_update <= 1'b0;
    for (i = 0; i < 6; i++) rd_chk(addr_tab[i], 1'b1, res[i]);
    rd_chk(5'h1a, 1'b0, `WORD_ZERO);
    rd_chk(5'h17, 1'b0, `WORD_ZERO);
    // writes to the first five result slots and to address 26 leave them alone
    for (i = 0; i < 5; i++) host_port_model_inst.wr(addr_tab[i], word_t'($random(seed)));
    host_port_model_inst.wr(5'h1a, 24'hff_ffff);
    for (i = 0; i < 6; i++) rd_chk(addr_tab[i], 1'b1, res[i]);
    $display("test results done");

    // each control bit alone, then ones in the undefined bits
    for (i = 1; i <= 8; i = i * 2)
    begin
      host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0001 << i);
      #1;
      chk({boot_stop, oscillator_disable}, {i == 8, i == 1}, "control levels");
      rd_chk(`ADDR_DEVICE_CONTROL, 1'b1, 24'h00_0001 << i);
    end
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'hff_ffff);
    rd_chk(`ADDR_DEVICE_CONTROL, 1'b1, `CTRL_WRITE_MASK);
    $display("test control done");

    // pins: normal drive, open drain, clock off then on again
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0000);
    pin_walk(1'b0);
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0010);
    pin_walk(1'b1);
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0004);
    repeat (2) @(posedge clk);
    count_clk(n);
    chk(n, 0, "clock parked");
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0000);
    repeat (4) @(posedge clk);
    count_clk(n);
    chk(n, 4, "clock running");
    $display("test pins done");

    // page select: off page the bank is silent and ignores control writes
    host_port_model_inst.wr(`ADDR_PAGE_SELECT, 24'h00_0001);
    #1;
    chk(page_select, 7'h01, "page select");
    rd_chk(`ADDR_IDENTITY_Q, 1'b0, `WORD_ZERO);
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0100);
    host_port_model_inst.wr(`ADDR_PAGE_SELECT, 24'hff_ff7f);
    #1;
    chk(page_select, 7'h7f, "page width");
    host_port_model_inst.wr(`ADDR_PAGE_SELECT, 24'h00_0000);
    rd_chk(`ADDR_DEVICE_CONTROL, 1'b1, `CTRL_RESET);
    rd_chk(`ADDR_FUNDAMENTAL_Q, 1'b1, res[5]);
    $display("test page done");

    // reset in mid-run returns page and control to zero
    host_port_model_inst.wr(`ADDR_DEVICE_CONTROL, 24'h00_0102);
    host_port_model_inst.wr(`ADDR_PAGE_SELECT, 24'h00_0003);
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({page_select, boot_stop, oscillator_disable}, 0, "second reset");
    rd_chk(`ADDR_FUNDAMENTAL_P, 1'b1, `WORD_ZERO);
    repeat (2) @(posedge clk);
    $display("test second reset done");
    wrap_up;
  end
endmodule // power_result_control_regs_test

`default_nettype wire
